// ---- dv/dual_timer_input_capture_bench.sv ----
// self-checking bench for the dual timer capture block
`include "dtic_defs.svh"
`define CHK(n,e,g) begin checked++; if ((g)!==(e)) begin n_errors++; $display("BAD %s exp %h got %h",n,e,g); end end
module dual_timer_input_capture_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, cut = 0, osc = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, d, a;
  logic [7:0]  preq = 0, pin, oe, cirq;
  logic [1:0]  br, rr, oirq, r;
  logic        awr, wrd, bv, arr, rv, cn, sub;
  int          n_errors = 0, checked = 0, cyc = 0;
  dual_timer_input_capture dut (.clk_sys_in(clk), .rst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .capture_pin_in(pin),
    .osc_div128_trigger_in(osc), .external_clock_pin_in(1'b0), .subclock_half_in(sub),
    .cutoff_input_pin_n_in(cn), .timer_oe_out(oe), .capture_irq_out(cirq), .overflow_irq_out(oirq));
  pin_partner far (.clk_sys_in(clk), .pin_req_in(preq), .cut_req_in(cut), .pin_out(pin), .cut_n_out(cn),
    .sub_out(sub));
  initial forever #4 clk = ~clk;
  // hang guard
  always @(posedge clk)
    if (++cyc == 20000)
    begin
      n_errors++;
      tally_and_finish;
    end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bus cycles hold everything until the matching ready is sampled
  task automatic wr(input [9:0] i, input [15:0] v);
    @(posedge clk);
    awa <= {i, 2'b0};
    wd <= {16'h0, v};
    {awv, wv, bre} <= 3'b111;
    do @(posedge clk); while (!(awr && wrd));
    {awv, wv} <= 2'b00;
    do @(posedge clk); while (!bv);
    r = br;
    bre <= 0;
  endtask
  task automatic rd(input [9:0] i);
    @(posedge clk);
    ara <= {i, 2'b0};
    {arv, rre} <= 2'b11;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    d = rdat;
    r = rr;
    rre <= 0;
  endtask
  task automatic rc(input [9:0] i, input [31:0] e, input string n);
    rd(i);
    `CHK(n, e, d)
  endtask
  task automatic t_regs;
    rc(`IDX_CLK_EXT, 32'h0, "ext");
    rc(`IDX_RUN, 32'hf0, "run");
    rc(`IDX_OUT_DIS, 32'hff, "dis");
    rd(10'h200);
    `CHK("resp", `RESP_SLVERR, r)
    wr(10'h200, 16'h0);
    `CHK("bresp", `RESP_SLVERR, r)
  endtask
  task automatic t_preset;
    wr(10'h146, 16'h1234);
    `CHK("bresp", `RESP_OKAY, r)
    rc(10'h146, 32'h1234, "own");
    rc(10'h156, 32'h0, "other");
    wr(`IDX_SYNC, 16'h1);
    wr(10'h156, 16'h0abc);
    rc(10'h146, 32'h0abc, "link");
  endtask
  task automatic t_run;
    logic [7:0] v [3];
    v = '{8'h0d, 8'h00, 8'h0c};
    // stop is honoured only with the operation select bit set
    for (int k = 0; k < 3; k++)
    begin
      wr(`IDX_RUN, {8'h0, v[k]});
      rd(10'h146);
      a = d;
      rd(10'h146);
      `CHK("cnt", k < 2, d !== a)
    end
  endtask
  task automatic t_cap;
    wr(`IDX_RUN, 16'h0c);
    wr(10'h146, 16'h2222);
    // counter zero clears on capture into A, counter one follows it
    wr(10'h140, 16'h20);
    wr(10'h150, 16'h60);
    wr(10'h141, 16'h4c);
    preq <= 8'h03;
    for (int k = 0; k < 12 && cirq[0] !== 1'b1; k++) @(posedge clk);
    `CHK("irq", 2'b11, cirq[1:0])
    rc(10'h148, 32'h2222, "cap");
    rc(10'h149, 32'h2222, "capb");
    rc(10'h146, 32'h0, "clr");
    rc(10'h156, 32'h0, "sclr");
    preq <= 8'h00;
  endtask
  task automatic t_osc;
    wr(10'h146, 16'h0555);
    wr(10'h141, 16'h04);
    osc <= 1'b1;
    for (int k = 0; k < 12 && cirq[0] !== 1'b1; k++) @(posedge clk);
    `CHK("oscirq", 1'b1, cirq[0])
    rc(10'h148, 32'h0555, "osc");
    osc <= 1'b0;
  endtask
  task automatic t_ovf;
    wr(10'h146, 16'hfff0);
    wr(`IDX_RUN, 16'h0f);
    for (int k = 0; k < 40 && oirq !== 2'b11; k++) @(posedge clk);
    `CHK("ovf", 2'b11, oirq)
  endtask
  task automatic t_cut;
    wr(`IDX_OUT_DIS, 16'h0);
    `CHK("oe", 8'hff, oe)
    wr(`IDX_CUTOFF, 16'h1);
    cut <= 1;
    repeat (5) @(posedge clk);
    `CHK("cut", 8'h00, oe)
    rc(`IDX_OUT_DIS, 32'hff, "dis");
    cut <= 0;
  endtask
  task automatic t_stby;
    wr(`IDX_CLK_EXT, 16'h88);
    rc(`IDX_CLK_EXT, 32'h88, "ext");
    wr(`IDX_RUN, 16'h0c);
    wr(`IDX_STANDBY, 16'h10);
    rc(`IDX_CLK_EXT, 32'h0, "stby");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_regs;
    t_preset;
    t_run;
    t_cap;
    t_osc;
    t_ovf;
    t_cut;
    t_stby;
    tally_and_finish;
  end
endmodule

// ---- dv/pin_partner.sv ----
// far-side model: capture pins, cutoff pin and subclock
module pin_partner
(
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] pin_req_in,
  input  wire logic       cut_req_in,
  output logic [7:0]      pin_out,
  output logic            cut_n_out,
  output logic            sub_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {pin_out, cut_n_out, sub_out} = 10'h002;
  // pins lag requests by a clock, as a board driver would
  always @(posedge clk_sys_in)
  begin
    pin_out   <= pin_req_in;
    cut_n_out <= ~cut_req_in;
    sub_out   <= ~sub_out;
  end
endmodule

// ---- verilog/capture_filter.sv ----
// pin conditioning: two-stage synchroniser, three-sample filter and edge detector
module capture_filter
(
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  input  wire logic                pin_in,
  input  wire logic                filter_en_in,
  input  wire dtic_pkg::edge_sel_t edge_sel_in,
  output logic                     event_out
);
  import dtic_pkg::*;

  logic sync_a;
  logic sync_b;
  logic hist_a;
  logic hist_b;
  logic level;
  logic level_q;
  logic rise;
  logic fall;
  logic agree;
  logic next_event;

  // edges of the accepted level, never of the raw pin
  assign rise  = level & ~level_q;
  assign fall  = ~level & level_q;
  assign agree = (sync_b == hist_a) && (hist_a == hist_b);

  // edge choice; the forbidden code gives no event at all
  always_comb
  begin
    unique case (edge_sel_in)
      EDGE_RISE: next_event = rise;
      EDGE_FALL: next_event = fall;
      EDGE_BOTH: next_event = rise | fall;
      default:   next_event = 1'b0;
    endcase
  end

  // sync_a feeds sync_b only, so metastability cannot reach the filter
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      hist_a    <= 1'b0;
      hist_b    <= 1'b0;
      level     <= 1'b0;
      level_q   <= 1'b0;
      event_out <= 1'b0;
    end
    else
    begin
      sync_a    <= pin_in;
      sync_b    <= sync_a;
      hist_a    <= sync_b;
      hist_b    <= hist_a;
      level_q   <= level;
      event_out <= next_event;
      if (!filter_en_in || agree)
        level <= sync_b;
    end
  end

endmodule

// ---- verilog/dtic_defs.svh ----
// register indices, field positions, reset values and bus answers of the dual timer
`ifndef DTIC_DEFS_SVH
`define DTIC_DEFS_SVH

`define IDX_W          10
`define IDX_STANDBY    10'h008
`define IDX_CLK_EXT    10'h135
`define IDX_RUN        10'h137
`define IDX_SYNC       10'h138
`define IDX_OUT_DIS    10'h13b
`define IDX_CUTOFF     10'h13c
`define IDX_FILT0      10'h13e
`define IDX_FILT1      10'h13f
`define IDX_BLOCK_LO   10'h135
`define IDX_BLOCK_HI   10'h15f
`define CNT_BLK        5'h0a
`define SUB_CTRL       4'h0
`define SUB_IOA        4'h1
`define SUB_IOC        4'h2
`define SUB_CNT        4'h6
`define SUB_GR_HI      2'h2

`define BIT_STANDBY    4
`define BIT_EXT0       3
`define BIT_EXT1       7
`define BIT_SYNC       0
`define BIT_CUT_EN     0
`define BIT_TRIG_SRC   3
`define BIT_CAP_LO     2
`define BIT_CAP_HI     6

`define RST_IO         8'h88
`define RST_OUT_DIS    8'hff
`define IOA_RSVD       8'h80
`define RUN_RSVD       4'hf
`define SYNC_RSVD      8'h0e
`define CNT_MAX        16'hffff

`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// ---- verilog/dtic_pkg.sv ----
// types shared by the dual timer input capture block
package dtic_pkg;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } edge_sel_t;

  typedef enum logic [2:0] {
    CLR_NONE = 3'b000,
    CLR_A    = 3'b001,
    CLR_B    = 3'b010,
    CLR_SYNC = 3'b011,
    CLR_C    = 3'b101,
    CLR_D    = 3'b110
  } clear_src_t;

  typedef enum logic [2:0] {
    SRC_F1   = 3'b000,
    SRC_F2   = 3'b001,
    SRC_F4   = 3'b010,
    SRC_F8   = 3'b011,
    SRC_F32  = 3'b100,
    SRC_EXT  = 3'b101,
    SRC_FAST = 3'b110,
    SRC_OSCF = 3'b111
  } count_src_t;

endpackage

// ---- verilog/dual_timer_input_capture.sv ----
// two 16-bit capture counters with synchronous preset/clear, cutoff and an AXI4-Lite register slave
//
// The AXI4-Lite slave port is this design's own decision.
`include "dtic_defs.svh"

module dual_timer_input_capture
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [7:0]  capture_pin_in,
  input  wire logic        osc_div128_trigger_in,
  input  wire logic        external_clock_pin_in,
  input  wire logic        subclock_half_in,
  input  wire logic        cutoff_input_pin_n_in,
  output logic [7:0]       timer_oe_out,
  output logic [7:0]       capture_irq_out,
  output logic [1:0]       overflow_irq_out
);
  import dtic_pkg::*;

  // bus state
  logic                aw_full;
  logic                w_full;
  logic [`IDX_W-1:0]   aw_idx;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  // software registers
  logic                standby;
  logic [1:0]          clk_ext;
  logic [1:0]          run;
  logic [1:0]          opsel;
  logic                sync_link;
  logic [7:0]          out_dis;
  logic                cut_en;
  logic [3:0]          filt [2];
  logic [7:0]          ctrl [2];
  logic [7:0]          ioa [2];
  logic [7:0]          ioc [2];
  logic [15:0]         cnt [2];
  logic [15:0]         gr [8];
  // timing and events
  logic [4:0]          pre;
  logic                cut_sync_a;
  logic                cut_sync_b;
  logic [7:0]          pin_evt;
  logic                osc_evt;
  logic [1:0]          ext_evt;
  logic                sub_evt;
  logic [7:0]          cap_evt;
  logic [7:0]          cap_mode;
  logic [7:0]          cap_taken;
  logic [1:0]          edge_raw [8];
  logic [1:0]          tick;
  logic [1:0]          ovf;
  logic [1:0]          own_clr;
  logic [1:0]          sync_clr;
  logic [1:0]          wr_cnt_hit;
  logic [1:0]          cnt_load;
  logic [15:0]         next_cnt [2];
  logic [15:0]         load_val;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  function automatic logic in_block(input logic [`IDX_W-1:0] idx);
    in_block = (idx >= `IDX_BLOCK_LO) && (idx <= `IDX_BLOCK_HI);
  endfunction

  function automatic logic is_mapped(input logic [`IDX_W-1:0] idx);
    logic [3:0] sub;
    sub = idx[3:0];
    is_mapped = (idx == `IDX_STANDBY) || (idx == `IDX_CLK_EXT) || (idx == `IDX_RUN) ||
                (idx == `IDX_SYNC) || (idx == `IDX_OUT_DIS) || (idx == `IDX_CUTOFF) ||
                (idx == `IDX_FILT0) || (idx == `IDX_FILT1) ||
                ((idx[9:5] == `CNT_BLK) && ((sub == `SUB_CTRL) || (sub == `SUB_IOA) ||
                 (sub == `SUB_IOC) || (sub == `SUB_CNT) || (sub[3:2] == `SUB_GR_HI)));
  endfunction

  // read value; standby hides the whole timer range
  function automatic logic [31:0] rd_word(input logic [`IDX_W-1:0] idx);
    logic u;
    u = idx[4];
    rd_word = 32'h0000_0000;
    if (!(standby && in_block(idx)))
    begin
      case (idx)
        `IDX_STANDBY: rd_word = {27'h0000000, standby, 4'h0};
        `IDX_CLK_EXT: rd_word = {24'h000000, clk_ext[1], 3'h0, clk_ext[0], 3'h0};
        `IDX_RUN:     rd_word = {24'h000000, `RUN_RSVD, opsel, run};
        `IDX_SYNC:    rd_word = {24'h000000, `SYNC_RSVD | {7'h00, sync_link}};
        `IDX_OUT_DIS: rd_word = {24'h000000, out_dis};
        `IDX_CUTOFF:  rd_word = {31'h00000000, cut_en};
        `IDX_FILT0:   rd_word = {28'h0000000, filt[0]};
        `IDX_FILT1:   rd_word = {28'h0000000, filt[1]};
        default:
        begin
          if (idx[9:5] == `CNT_BLK)
          begin
            if (idx[3:0] == `SUB_CTRL)
              rd_word = {24'h000000, ctrl[u]};
            else if (idx[3:0] == `SUB_IOA)
              rd_word = {24'h000000, ioa[u]};
            else if (idx[3:0] == `SUB_IOC)
              rd_word = {24'h000000, ioc[u]};
            else if (idx[3:0] == `SUB_CNT)
              rd_word = {16'h0000, cnt[u]};
            else if (idx[3:2] == `SUB_GR_HI)
              rd_word = {16'h0000, gr[{u, idx[1:0]}]};
          end
        end
      endcase
    end
  endfunction

  // write decode; a blocked write is answered but has no effect
  logic                ar_hs;
  logic [`IDX_W-1:0]   ar_idx;
  logic                do_wr;
  logic                wr_ok;
  logic                wr_lo;
  logic                wr_cnt_blk;
  logic                wr_unit;
  logic [3:0]          wr_sub;
  logic                hit_standby;
  logic                hit_clk_ext;
  logic                hit_run;
  logic                hit_sync;
  logic                hit_out_dis;
  logic                hit_cutoff;
  logic                cut_active;

  assign s_axi_awready_out = ~aw_full;
  assign s_axi_wready_out  = ~w_full;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign ar_hs       = s_axi_arvalid_in & ~s_axi_rvalid_out;
  assign ar_idx      = s_axi_araddr_in[11:2];
  assign do_wr       = aw_full & w_full & ~s_axi_bvalid_out;
  assign wr_ok       = do_wr & ~(standby & in_block(aw_idx));
  assign wr_lo       = wr_ok & w_strb[0];
  assign wr_cnt_blk  = wr_ok & (aw_idx[9:5] == `CNT_BLK);
  assign wr_unit     = aw_idx[4];
  assign wr_sub      = aw_idx[3:0];
  assign hit_standby = wr_lo & (aw_idx == `IDX_STANDBY);
  assign hit_clk_ext = wr_lo & (aw_idx == `IDX_CLK_EXT);
  assign hit_run     = wr_lo & (aw_idx == `IDX_RUN);
  assign hit_sync    = wr_lo & (aw_idx == `IDX_SYNC);
  assign hit_out_dis = wr_lo & (aw_idx == `IDX_OUT_DIS);
  assign hit_cutoff  = wr_lo & (aw_idx == `IDX_CUTOFF);
  assign load_val    = merge16(cnt[wr_unit], w_data[15:0], w_strb[1:0]);

  // cutoff acts straight from the synchronised pin so the pins let go within two clocks
  assign cut_active   = cut_en & ~cut_sync_b;
  assign timer_oe_out = ~out_dis & ~{8{cut_active}};

  // pin conditioning for all eight capture pins
  for (genvar k = 0; k < 8; k++)
  begin : g_pin
    capture_filter u_filter
    (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .pin_in       (capture_pin_in[k]),
      .filter_en_in (filt[k / 4][k % 4]),
      .edge_sel_in  (edge_sel_t'(edge_raw[k])),
      .event_out    (pin_evt[k])
    );
  end

  // oscillator trigger uses the edge choice of register A of counter zero
  capture_filter u_osc
  (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .pin_in       (osc_div128_trigger_in),
    .filter_en_in (1'b0),
    .edge_sel_in  (edge_sel_t'(edge_raw[0])),
    .event_out    (osc_evt)
  );

  // subclock half counts on its rising edge
  capture_filter u_sub
  (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .pin_in       (subclock_half_in),
    .filter_en_in (1'b0),
    .edge_sel_in  (EDGE_RISE),
    .event_out    (sub_evt)
  );

  // per-counter edge fields, capture enables, clock and counter logic
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    wire [2:0] src = ctrl[u][2:0];
    wire [2:0] sel = ctrl[u][7:5];
    wire       src_tick;

    assign edge_raw[u*4+0] = ioa[u][1:0];
    assign edge_raw[u*4+1] = ioa[u][5:4];
    assign edge_raw[u*4+2] = ioc[u][1:0];
    assign edge_raw[u*4+3] = ioc[u][5:4];
    assign cap_mode[u*4+3:u*4] = {ioc[u][`BIT_CAP_HI], ioc[u][`BIT_CAP_LO],
                                  ioa[u][`BIT_CAP_HI], ioa[u][`BIT_CAP_LO]};

    // the external pin is shared; each counter keeps its own edge choice
    capture_filter u_ext
    (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .pin_in       (external_clock_pin_in),
      .filter_en_in (1'b0),
      .edge_sel_in  (edge_sel_t'(ctrl[u][4:3])),
      .event_out    (ext_evt[u])
    );

    // the two oscillator codes count at the operating clock rate here
    assign src_tick = (src == SRC_F2)  ? pre[0] :
                      (src == SRC_F4)  ? (&pre[1:0]) :
                      (src == SRC_F8)  ? (&pre[2:0]) :
                      (src == SRC_F32) ? (&pre[4:0]) :
                      (src == SRC_EXT) ? (clk_ext[u] ? sub_evt : ext_evt[u]) :
                      1'b1;
    assign tick[u] = run[u] & src_tick;
    assign ovf[u]  = tick[u] & (cnt[u] == `CNT_MAX);

    // capture-based clear of this counter
    assign own_clr[u] = ((sel == CLR_A) & cap_taken[u*4+0]) |
                        ((sel == CLR_B) & cap_taken[u*4+1]) |
                        ((sel == CLR_C) & cap_taken[u*4+2]) |
                        ((sel == CLR_D) & cap_taken[u*4+3]);
    // linked clear follows the other counter going to zero, never its own
    assign sync_clr[u] = sync_link & (sel == CLR_SYNC) & (own_clr[1-u] | ovf[1-u]);

    assign wr_cnt_hit[u] = wr_cnt_blk & (wr_unit == u) & (wr_sub == `SUB_CNT);
    assign cnt_load[u]   = sync_link ? (|wr_cnt_hit) : wr_cnt_hit[u];
    assign next_cnt[u]   = cnt_load[u] ? load_val :
                           (own_clr[u] | sync_clr[u]) ? 16'h0000 :
                           tick[u] ? cnt[u] + 16'h0001 : cnt[u];
  end

  // register A of counter zero picks the pin or the oscillator trigger
  assign cap_evt   = {pin_evt[7:1], ioa[0][`BIT_TRIG_SRC] ? pin_evt[0] : osc_evt};
  assign cap_taken = cap_evt & cap_mode;

  // AXI4-Lite handshakes; one write and one read at a time
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      aw_full          <= 1'b0;
      w_full           <= 1'b0;
      aw_idx           <= '0;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `RESP_OKAY;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_idx  <= s_axi_awaddr_in[11:2];
      end
      else if (do_wr)
        aw_full <= 1'b0;
      if (s_axi_wvalid_in && !w_full)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      else if (do_wr)
        w_full <= 1'b0;
      if (do_wr)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= is_mapped(aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      if (ar_hs)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_word(ar_idx);
        s_axi_rresp_out  <= is_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

  // control registers; cutoff wins over a software write of the disable bits
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      standby    <= 1'b0;
      clk_ext    <= 2'b00;
      run        <= 2'b00;
      opsel      <= 2'b00;
      sync_link  <= 1'b0;
      out_dis    <= `RST_OUT_DIS;
      cut_en     <= 1'b0;
      cut_sync_a <= 1'b1;
      cut_sync_b <= 1'b1;
      pre        <= 5'h00;
    end
    else
    begin
      cut_sync_a <= cutoff_input_pin_n_in;
      cut_sync_b <= cut_sync_a;
      pre        <= pre + 5'h01;
      if (hit_standby)
        standby <= w_data[`BIT_STANDBY];
      if (hit_clk_ext)
        clk_ext <= {w_data[`BIT_EXT1], w_data[`BIT_EXT0]};
      if (hit_run)
      begin
        run   <= w_data[1:0] | (run & ~w_data[3:2]);
        opsel <= w_data[3:2];
      end
      if (hit_sync)
        sync_link <= w_data[`BIT_SYNC];
      if (cut_active)
        out_dis <= `RST_OUT_DIS;
      else if (hit_out_dis)
        out_dis <= w_data[7:0];
      if (hit_cutoff)
        cut_en <= w_data[`BIT_CUT_EN];
    end
  end

  // per-counter registers; a capture beats a software write to the same register
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 2; i++)
      begin
        filt[i] <= 4'h0;
        ctrl[i] <= 8'h00;
        ioa[i]  <= `RST_IO;
        ioc[i]  <= `RST_IO;
        cnt[i]  <= 16'h0000;
      end
      for (int k = 0; k < 8; k++)
        gr[k] <= 16'h0000;
      capture_irq_out  <= 8'h00;
      overflow_irq_out <= 2'b00;
    end
    else
    begin
      capture_irq_out  <= cap_taken;
      overflow_irq_out <= ovf;
      for (int i = 0; i < 2; i++)
      begin
        cnt[i] <= next_cnt[i];
        if (wr_lo && aw_idx == (i[0] ? `IDX_FILT1 : `IDX_FILT0))
          filt[i] <= w_data[3:0];
        if (wr_cnt_blk && w_strb[0] && wr_unit == i[0])
        begin
          if (wr_sub == `SUB_CTRL)
            ctrl[i] <= w_data[7:0];
          if (wr_sub == `SUB_IOA)
            ioa[i] <= w_data[7:0] | `IOA_RSVD;
          if (wr_sub == `SUB_IOC)
            ioc[i] <= w_data[7:0];
        end
      end
      for (int k = 0; k < 8; k++)
      begin
        if (cap_taken[k])
          gr[k] <= cnt[k / 4];
        else if (wr_cnt_blk && wr_sub[3:2] == `SUB_GR_HI && {wr_unit, wr_sub[1:0]} == k[2:0])
          gr[k] <= merge16(gr[k], w_data[15:0], w_strb[1:0]);
      end
    end
  end

  // checks next to the logic they guard
  chk_cutoff_disable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cut_active |=> out_dis == 8'hff) else $error("cutoff did not set all disable bits");

  chk_cutoff_release: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cut_en && !cutoff_input_pin_n_in ##2 cut_en |-> timer_oe_out == 8'h00)
    else $error("timer pins still driven in cutoff");

  chk_oe_gating: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (timer_oe_out & out_dis) == 8'h00) else $error("pin driven while its disable bit is set");

  chk_sync_preset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sync_link && (|wr_cnt_hit) |=> cnt[0] == cnt[1]) else $error("linked write did not load both");

  chk_free_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tick[0] && cnt[0] == 16'hffff && !cnt_load[0] && !sync_clr[0] && !own_clr[0]
    |=> cnt[0] == 16'h0000 && overflow_irq_out[0]) else $error("counter zero did not wrap");

  chk_capture_copy: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cap_taken[1] |=> gr[1] == $past(cnt[0])) else $error("capture did not copy counter");

  chk_run_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    hit_run && w_data[1] |=> run[1]) else $error("run flag did not start counter");

  chk_run_stop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    hit_run && !w_data[0] |=> run[0] == ($past(run[0]) && !$past(w_data[2])))
    else $error("run flag stop ignored operation select");

  chk_standby_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ar_hs && standby && in_block(ar_idx) |=> s_axi_rdata_out == 32'h0000_0000)
    else $error("timer register read in standby");

  chk_sync_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sync_link && ctrl[1][7:5] == 3'b011 && own_clr[0] && !cnt_load[1] |=> cnt[1] == 16'h0000)
    else $error("linked counter did not clear");

  chk_osc_trigger: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    osc_evt && !ioa[0][3] && ioa[0][2] |=> capture_irq_out[0]) else $error("oscillator capture lost");

endmodule
